// file: logic/cpu_logic_move_bit_instr_exec.sv
module cpu_logic_move_bit_instr_exec (
  input  logic             clk,
  input  logic             rst_n,
  input  logic             ce,
  input  logic             start,
  input  ep::op_t          op,
  input  ep::logic_fn_t    fn,
  input  logic [2:0]       reg_sel,
  input  logic [7:0]       byte1,
  input  logic [7:0]       byte2,
  input  logic [15:0]      next_pc,
  input  logic [1:0]       bank_sel,
  output logic             ready,
  output logic             done,
  output logic             illegal,
  output logic             ext_rd,
  output logic             ext_wr,
  output ep::mem_space_t   ext_space,
  output logic [15:0]      ext_addr,
  output logic [7:0]       ext_wdata,
  input  logic [7:0]       ext_rdata,
  output logic [7:0]       acc,
  output logic             carry,
  output logic [15:0]      ptr16,
  output logic [7:0]       stack_ptr,
  output logic             jump_taken,
  output logic [15:0]      jump_target
);

  // ************************************************************
  // state
  // ************************************************************
  ep::state_t       state_ff;
  ep::op_t          op_ff;
  ep::logic_fn_t    fn_ff;
  logic [2:0]       reg_ff;
  logic [7:0]       b1_ff;
  logic [7:0]       b2_ff;
  logic [15:0]      npc_ff;
  logic [1:0]       bank_ff;
  logic [2:0]       cnt_ff;
  logic [2:0]       ncyc_ff;
  logic [7:0]       rd_ff;
  logic [7:0]       acc_ff;
  logic             c_ff;
  logic [15:0]      ptr_ff;
  logic [7:0]       sp_ff;
  logic [7:0]       ram_ff [ep::RAM_DEPTH];
  logic             jmp_ff;
  logic [15:0]      tgt_ff;

  logic             run;
  logic             last;
  logic             take;

  assign run   = state_ff == ep::st_run;
  assign last  = run && (cnt_ff == ncyc_ff - ep::CYC_ONE);
  assign ready = (state_ff == ep::st_idle) || last;
  assign take  = ce && start && ready;
  assign done  = ce && last;
  // codes past the last kind run as a one-cycle no-op
  assign illegal = done && (op_ff > ep::op_jmp_test_clr);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ep::st_idle;
      cnt_ff   <= ep::CNT_RD_ISSUE;
    end else if (ce) begin
      unique case (state_ff)
        ep::st_idle: begin
          if (start) begin
            state_ff <= ep::st_run;
            cnt_ff   <= ep::CNT_RD_ISSUE;
          end
        end
        ep::st_run: begin
          if (last) begin
            state_ff <= start ? ep::st_run : ep::st_idle;
            cnt_ff   <= ep::CNT_RD_ISSUE;
          end else begin
            cnt_ff <= cnt_ff + ep::CYC_ONE;
          end
        end
        default: begin
          state_ff <= ep::st_idle;
          cnt_ff   <= ep::CNT_RD_ISSUE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_ff   <= ep::op_nop;
      fn_ff   <= ep::and_op;
      reg_ff  <= 3'h0;
      b1_ff   <= ep::ZERO_BYTE;
      b2_ff   <= ep::ZERO_BYTE;
      npc_ff  <= 16'h0000;
      bank_ff <= 2'h0;
      ncyc_ff <= ep::CYC_ONE;
    end else if (take) begin
      op_ff   <= op;
      fn_ff   <= fn;
      reg_ff  <= reg_sel;
      b1_ff   <= byte1;
      b2_ff   <= byte2;
      npc_ff  <= next_pc;
      bank_ff <= bank_sel;
      ncyc_ff <= ep::op_cycles(op);
    end
  end

  // ************************************************************
  // operands
  // ************************************************************
  logic [7:0]  reg_adr;
  logic [7:0]  idx_adr;
  logic [7:0]  ind_adr;
  logic [7:0]  reg_val;
  logic [7:0]  ind_val;
  logic [7:0]  ext_val;
  logic        dir_ext;
  logic [7:0]  dir_val;
  logic [7:0]  bit_adr;
  logic        bit_ext;
  logic [7:0]  bit_byte;
  logic [7:0]  bit_mask;
  logic        bit_val;
  logic        is_bit;
  logic [7:0]  rel;
  logic [15:0] rel_tgt;

  assign reg_adr = {ep::BANK_HI, bank_ff, reg_ff};
  assign idx_adr = {ep::BANK_HI, bank_ff, ep::IDX_PAD, reg_ff[0]};
  assign ind_adr = ram_ff[idx_adr];
  assign reg_val = ram_ff[reg_adr];
  assign ind_val = ram_ff[ind_adr];
  // data is on the port one cycle after the read, held in rd_ff later
  assign ext_val = (cnt_ff == ep::CNT_RD_DATA) ? ext_rdata : rd_ff;
  assign dir_ext = b1_ff[ep::DIR_SPC_BIT];
  assign dir_val = dir_ext ? ext_val : ram_ff[b1_ff];
  assign bit_ext = b1_ff[ep::DIR_SPC_BIT];
  assign bit_adr = bit_ext ? {b1_ff[7:3], 3'h0} :
                   ep::BIT_RAM_BASE + {4'h0, b1_ff[6:3]};
  assign bit_byte = bit_ext ? ext_val : ram_ff[bit_adr];
  assign bit_mask = ep::STEP << b1_ff[2:0];
  assign bit_val  = bit_byte[b1_ff[2:0]];
  // carry jumps hold an offset in byte1, so they must not fetch a bit byte
  assign is_bit   = (op_ff >= ep::op_clr_bit) &&
                    !(op_ff inside {ep::op_jmp_c_set, ep::op_jmp_c_clr});
  assign rel      = (op_ff >= ep::op_jmp_bit_set) ? b2_ff : b1_ff;
  assign rel_tgt  = npc_ff + {{8{rel[7]}}, rel};

  function automatic logic [7:0] lf(input logic [7:0] a,
                                    input logic [7:0] b);
    logic [7:0] r;
    r = a & b;
    case (fn_ff)
      ep::or_op:  r = a | b;
      ep::xor_op: r = a ^ b;
      default:    r = a & b;
    endcase
    return r;
  endfunction

  // ************************************************************
  // execution
  // ************************************************************
  logic [7:0]      n_acc;
  logic            n_c;
  logic [15:0]     n_ptr;
  logic [7:0]      n_sp;
  logic            n_jmp;
  logic            iw_en;
  logic [7:0]      iw_adr;
  logic [7:0]      iw_dat;
  logic            dw_en;
  logic [7:0]      dw_adr;
  logic [7:0]      dw_dat;
  logic            xw_en;
  logic [15:0]     xw_adr;
  logic            rd_req;
  ep::mem_space_t  rd_space;
  logic [15:0]     rd_adr;

  always_comb begin
    n_acc    = acc_ff;
    n_c      = c_ff;
    n_ptr    = ptr_ff;
    n_sp     = sp_ff;
    n_jmp    = 1'b0;
    iw_en    = 1'b0;
    iw_adr   = ind_adr;
    iw_dat   = acc_ff;
    dw_en    = 1'b0;
    dw_adr   = is_bit ? bit_adr : b1_ff;
    dw_dat   = acc_ff;
    xw_en    = 1'b0;
    xw_adr   = ptr_ff;
    rd_req   = is_bit && bit_ext;
    rd_space = ep::ms_special;
    rd_adr   = {ep::ZERO_BYTE, dw_adr};
    case (op_ff)
      ep::op_la_reg: n_acc = lf(acc_ff, reg_val);
      ep::op_la_dir: begin
        n_acc  = lf(acc_ff, dir_val);
        rd_req = dir_ext;
      end
      ep::op_la_ind: n_acc = lf(acc_ff, ind_val);
      ep::op_la_imm: n_acc = lf(acc_ff, b1_ff);
      ep::op_ld_acc, ep::op_ld_imm: begin
        rd_req = dir_ext;
        dw_en  = 1'b1;
        dw_dat = lf(dir_val, (op_ff == ep::op_ld_acc) ? acc_ff : b2_ff);
      end
      ep::op_clr_a:       n_acc = ep::ZERO_BYTE;
      ep::op_invert_a:    n_acc = ~acc_ff;
      ep::op_rot_left:    n_acc = {acc_ff[6:0], acc_ff[7]};
      ep::op_rot_right:   n_acc = {acc_ff[0], acc_ff[7:1]};
      ep::op_rot_left_c:  {n_c, n_acc} = {acc_ff, c_ff};
      ep::op_rot_right_c: {n_acc, n_c} = {c_ff, acc_ff};
      ep::op_nib_swap:    n_acc = {acc_ff[3:0], acc_ff[7:4]};
      ep::op_cp_a_reg:    n_acc = reg_val;
      ep::op_cp_a_dir: begin
        n_acc  = dir_val;
        rd_req = dir_ext;
      end
      ep::op_cp_a_ind:    n_acc = ind_val;
      ep::op_cp_a_imm:    n_acc = b1_ff;
      ep::op_cp_reg_a, ep::op_cp_reg_dir, ep::op_cp_reg_imm: begin
        iw_en  = 1'b1;
        iw_adr = reg_adr;
        rd_req = dir_ext && (op_ff == ep::op_cp_reg_dir);
        iw_dat = (op_ff == ep::op_cp_reg_a) ? acc_ff :
                 (op_ff == ep::op_cp_reg_dir) ? dir_val : b1_ff;
      end
      ep::op_cp_dir_a:    dw_en = 1'b1;
      ep::op_cp_dir_reg: begin
        dw_en  = 1'b1;
        dw_dat = reg_val;
      end
      ep::op_cp_dir_dir: begin
        rd_req = dir_ext;
        dw_en  = 1'b1;
        dw_adr = b2_ff;
        dw_dat = dir_val;
      end
      ep::op_cp_dir_ind: begin
        dw_en  = 1'b1;
        dw_dat = ind_val;
      end
      ep::op_cp_dir_imm: begin
        dw_en  = 1'b1;
        dw_dat = b2_ff;
      end
      ep::op_cp_ind_a:    iw_en = 1'b1;
      ep::op_cp_ind_dir: begin
        rd_req = dir_ext;
        iw_en  = 1'b1;
        iw_dat = dir_val;
      end
      ep::op_cp_ind_imm: begin
        iw_en  = 1'b1;
        iw_dat = b1_ff;
      end
      ep::op_load_ptr:    n_ptr = {b1_ff, b2_ff};
      ep::op_code_ptr, ep::op_code_prog: begin
        rd_req   = 1'b1;
        rd_space = ep::ms_code;
        rd_adr   = ((op_ff == ep::op_code_ptr) ? ptr_ff : npc_ff) +
                   {ep::ZERO_BYTE, acc_ff};
        n_acc    = ext_val;
      end
      ep::op_xram_rd_ind, ep::op_xram_rd_ptr: begin
        rd_req   = 1'b1;
        rd_space = ep::ms_xram;
        rd_adr   = (op_ff == ep::op_xram_rd_ptr) ? ptr_ff :
                   {ep::XRAM_PAGE, ind_adr};
        n_acc    = ext_val;
      end
      ep::op_xram_wr_ind: begin
        xw_en  = 1'b1;
        xw_adr = {ep::XRAM_PAGE, ind_adr};
      end
      ep::op_xram_wr_ptr: xw_en = 1'b1;
      ep::op_push: begin
        rd_req = dir_ext;
        n_sp   = sp_ff + ep::STEP;
        iw_en  = 1'b1;
        iw_adr = n_sp;
        iw_dat = dir_val;
      end
      ep::op_pop: begin
        dw_en  = 1'b1;
        dw_dat = ram_ff[sp_ff];
        n_sp   = sp_ff - ep::STEP;
      end
      ep::op_trade_reg: begin
        n_acc  = reg_val;
        iw_en  = 1'b1;
        iw_adr = reg_adr;
      end
      ep::op_trade_dir: begin
        rd_req = dir_ext;
        n_acc  = dir_val;
        dw_en  = 1'b1;
      end
      ep::op_trade_ind: begin
        n_acc = ind_val;
        iw_en = 1'b1;
      end
      ep::op_trade_digit: begin
        n_acc  = {acc_ff[7:4], ind_val[3:0]};
        iw_en  = 1'b1;
        iw_dat = {ind_val[7:4], acc_ff[3:0]};
      end
      ep::op_clr_c:    n_c = 1'b0;
      ep::op_set_c:    n_c = 1'b1;
      ep::op_invert_c: n_c = ~c_ff;
      ep::op_clr_bit, ep::op_set_bit, ep::op_invert_bit,
      ep::op_bit_from_c: begin
        dw_en  = 1'b1;
        dw_dat = (op_ff == ep::op_set_bit) ? (bit_byte | bit_mask) :
                 (op_ff == ep::op_invert_bit) ? (bit_byte ^ bit_mask) :
                 (op_ff == ep::op_bit_from_c && c_ff) ?
                 (bit_byte | bit_mask) : (bit_byte & ~bit_mask);
      end
      ep::op_and_c:      n_c = c_ff & bit_val;
      ep::op_andn_c:     n_c = c_ff & ~bit_val;
      ep::op_or_c:       n_c = c_ff | bit_val;
      ep::op_orn_c:      n_c = c_ff | ~bit_val;
      ep::op_c_from_bit: n_c = bit_val;
      ep::op_jmp_c_set:   n_jmp = c_ff;
      ep::op_jmp_c_clr:   n_jmp = ~c_ff;
      ep::op_jmp_bit_set: n_jmp = bit_val;
      ep::op_jmp_bit_clr: n_jmp = ~bit_val;
      ep::op_jmp_test_clr: begin
        n_jmp  = bit_val;
        dw_en  = bit_val;
        dw_dat = bit_byte & ~bit_mask;
      end
      default: n_jmp = 1'b0;
    endcase
  end

  // ************************************************************
  // write routing and memory port
  // ************************************************************
  logic            ram_we;
  logic [7:0]      ram_wa;
  logic [7:0]      ram_wd;
  logic            ew_en;

  // direct writes above the ram half go to the special registers
  assign ram_we = done && (iw_en || (dw_en && !dw_adr[ep::DIR_SPC_BIT]));
  assign ram_wa = iw_en ? iw_adr : dw_adr;
  assign ram_wd = iw_en ? iw_dat : dw_dat;
  assign ew_en  = xw_en || (dw_en && dw_adr[ep::DIR_SPC_BIT]);

  assign ext_rd    = ce && run && (cnt_ff == ep::CNT_RD_ISSUE) && rd_req;
  assign ext_wr    = done && ew_en;
  assign ext_space = ext_wr ? (xw_en ? ep::ms_xram : ep::ms_special) :
                     rd_space;
  assign ext_addr  = ext_wr ? (xw_en ? xw_adr : {ep::ZERO_BYTE, dw_adr}) :
                     rd_adr;
  assign ext_wdata = xw_en ? acc_ff : dw_dat;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ff <= ep::ZERO_BYTE;
    end else if (ce && run && cnt_ff == ep::CNT_RD_DATA) begin
      rd_ff <= ext_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ep::RAM_DEPTH; i++) begin
        ram_ff[i] <= ep::ZERO_BYTE;
      end
    end else if (ram_we) begin
      ram_ff[ram_wa] <= ram_wd;
    end
  end

  // ************************************************************
  // core registers
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= ep::ZERO_BYTE;
      c_ff   <= 1'b0;
      ptr_ff <= 16'h0000;
      sp_ff  <= ep::SP_RESET;
    end else if (done) begin
      acc_ff <= n_acc;
      c_ff   <= n_c;
      ptr_ff <= n_ptr;
      sp_ff  <= n_sp;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      jmp_ff <= 1'b0;
      tgt_ff <= 16'h0000;
    end else if (done) begin
      jmp_ff <= n_jmp;
      if (n_jmp) begin
        tgt_ff <= rel_tgt;
      end
    end
  end

  assign acc         = acc_ff;
  assign carry       = c_ff;
  assign ptr16       = ptr_ff;
  assign stack_ptr   = sp_ff;
  assign jump_taken  = jmp_ff;
  assign jump_target = tgt_ff;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);

  AST_LOG_REG_ONE: assert property (
    take && op == ep::op_la_reg |=> done)
    else $error("logic from bank reg not one cycle");
  AST_LOG_DIR_TWO: assert property (
    take && op == ep::op_la_dir |=> !done ##1 done)
    else $error("logic from direct not two cycles");
  AST_LOG_TO_DIR: assert property (
    take && op inside {ep::op_ld_acc, ep::op_ld_imm}
    |=> !done [*2] ##1 (done && (ram_we || ext_wr)))
    else $error("logic into direct not three cycles with write");
  AST_ACC_ONE: assert property (
    take && op inside {ep::op_clr_a, ep::op_invert_a, ep::op_nib_swap}
    |=> done)
    else $error("acc operation not one cycle");
  AST_RING: assert property (
    done && op_ff == ep::op_rot_left_c
    |=> acc == {$past(acc_ff[6:0]), $past(c_ff)} &&
        carry == $past(acc_ff[7]))
    else $error("carry rotate ring wrong");
  AST_XRAM_ACC: assert property (
    ext_wr && ext_space == ep::ms_xram |-> ext_wdata == acc)
    else $error("xram write not from acc");
  AST_CODE_PTR: assert property (
    ext_rd && ext_space == ep::ms_code && op_ff == ep::op_code_ptr
    |-> !done [*4] ##1 done ##1 acc == $past(rd_ff))
    else $error("pointer code read timing or data wrong");
  AST_XRAM_RD_IND: assert property (
    take && op == ep::op_xram_rd_ind |=> !done [*3] ##1 done)
    else $error("xram indirect read not four cycles");
  AST_DIR_SPACE: assert property (
    (ext_rd || ext_wr) && ext_space == ep::ms_special
    |-> ext_addr[15:8] == ep::ZERO_BYTE && ext_addr[ep::DIR_SPC_BIT])
    else $error("direct access left the special register half");
  AST_TEST_CLR_KEEP: assert property (
    done && op_ff == ep::op_jmp_test_clr && !bit_val
    |-> !ext_wr && !ram_we ##1 !jump_taken)
    else $error("clear bit touched or branch taken");
  AST_JC_TARGET: assert property (
    done && op_ff == ep::op_jmp_c_set && c_ff
    |=> jump_taken && jump_target == $past(rel_tgt))
    else $error("carry jump not taken to target");

  COV_TEST_CLR: cover property (done && op_ff == ep::op_jmp_test_clr
                                && bit_val);
  COV_DIGIT: cover property (done && op_ff == ep::op_trade_digit);
  COV_XRAM_WR: cover property (ext_wr && ext_space == ep::ms_xram);
  COV_BACK2BACK: cover property (take && last);

endmodule

// file: logic/ep.sv
package ep;

  // ************************************************************
  // instruction kinds (la_* logic into acc, ld_* logic into direct)
  // ************************************************************
  typedef enum logic [5:0] {
    op_nop, op_la_reg, op_la_dir, op_la_ind, op_la_imm, op_ld_acc,
    op_ld_imm, op_clr_a, op_invert_a, op_rot_left, op_rot_left_c,
    op_rot_right, op_rot_right_c, op_nib_swap,
    op_cp_a_reg, op_cp_a_dir, op_cp_a_ind, op_cp_a_imm, op_cp_reg_a,
    op_cp_reg_dir, op_cp_reg_imm, op_cp_dir_a, op_cp_dir_reg,
    op_cp_dir_dir, op_cp_dir_ind, op_cp_dir_imm, op_cp_ind_a,
    op_cp_ind_dir, op_cp_ind_imm, op_load_ptr, op_code_ptr,
    op_code_prog, op_xram_rd_ind, op_xram_rd_ptr, op_xram_wr_ind,
    op_xram_wr_ptr, op_push, op_pop, op_trade_reg, op_trade_dir,
    op_trade_ind, op_trade_digit, op_clr_c, op_set_c, op_invert_c,
    op_clr_bit, op_set_bit, op_invert_bit, op_and_c, op_andn_c,
    op_or_c, op_orn_c, op_c_from_bit, op_bit_from_c, op_jmp_c_set,
    op_jmp_c_clr, op_jmp_bit_set, op_jmp_bit_clr, op_jmp_test_clr
  } op_t;

  typedef enum logic [1:0] {and_op, or_op, xor_op} logic_fn_t;
  typedef enum logic [1:0] {ms_special, ms_xram, ms_code} mem_space_t;
  typedef enum logic [1:0] {st_idle = 2'b01, st_run = 2'b10} state_t;

  // ************************************************************
  // constants
  // ************************************************************
  localparam logic [2:0] CYC_ONE     = 3'h1;
  localparam logic [2:0] CYC_TWO     = 3'h2;
  localparam logic [2:0] CYC_THREE   = 3'h3;
  localparam logic [2:0] CYC_FOUR    = 3'h4;
  localparam logic [2:0] CYC_FIVE    = 3'h5;
  localparam logic [2:0] CNT_RD_ISSUE = 3'h0;
  localparam logic [2:0] CNT_RD_DATA  = 3'h1;
  localparam logic [7:0] SP_RESET     = 8'h07;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;
  localparam logic [7:0] XRAM_PAGE    = 8'h00;
  localparam logic [7:0] STEP         = 8'h01;
  localparam logic [2:0] BANK_HI      = 3'h0;
  localparam logic [1:0] IDX_PAD      = 2'h0;
  localparam int         DIR_SPC_BIT  = 7;
  localparam int         RAM_DEPTH    = 256;

  function automatic logic [2:0] op_cycles(input op_t op);
    logic [2:0] c;
    c = CYC_ONE;
    case (op)
      op_la_dir, op_la_ind, op_la_imm, op_cp_a_dir, op_cp_a_ind,
      op_cp_a_imm, op_cp_reg_imm, op_cp_dir_a, op_cp_dir_reg,
      op_cp_ind_a, op_cp_ind_imm, op_pop, op_trade_reg, op_and_c,
      op_andn_c, op_or_c, op_orn_c, op_c_from_bit: c = CYC_TWO;
      op_ld_acc, op_ld_imm, op_cp_reg_dir, op_cp_dir_dir,
      op_cp_dir_ind, op_cp_dir_imm, op_cp_ind_dir, op_load_ptr,
      op_xram_rd_ptr, op_push, op_trade_dir, op_trade_ind,
      op_trade_digit, op_clr_bit, op_set_bit, op_invert_bit,
      op_bit_from_c, op_jmp_c_set, op_jmp_c_clr: c = CYC_THREE;
      op_code_prog, op_xram_rd_ind, op_xram_wr_ptr: c = CYC_FOUR;
      op_code_ptr, op_xram_wr_ind, op_jmp_bit_set, op_jmp_bit_clr,
      op_jmp_test_clr: c = CYC_FIVE;
      default: c = CYC_ONE;
    endcase
    return c;
  endfunction

endpackage

// file: test/ext_mem_model.sv
module ext_mem_model (
  input  wire logic           clk,
  input  wire logic           ext_rd,
  input  wire logic           ext_wr,
  input  wire ep::mem_space_t ext_space,
  input  wire logic [15:0]    ext_addr,
  input  wire logic [7:0]     ext_wdata,
  output logic      [7:0]     ext_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [3][256];

  initial begin
    ext_rdata = 8'h00;
    for (int s = 0; s < 3; s++)
      for (int a = 0; a < 256; a++)
        mem[s][a] = 8'(a) ^ 8'ha5 ^ 8'(s);
  end

  // data holds one cycle only, then a moving pattern hides stale bytes
  always @(posedge clk) begin
    if (ext_rd) ext_rdata <= mem[int'(ext_space)][ext_addr[7:0]];
    else ext_rdata <= 8'($urandom);
    if (ext_wr) mem[int'(ext_space)][ext_addr[7:0]] <= ext_wdata;
  end
endmodule

// file: test/cpu_logic_move_bit_instr_exec_bench.sv
module cpu_logic_move_bit_instr_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {time t0; int n; logic [7:0] a; logic c; logic j;
                  logic [15:0] p; logic [7:0] s;} note_t;
  logic clk, rst_n, ce, start, ready, done, illegal, ext_rd, ext_wr;
  logic carry, jump_taken;
  logic [2:0] reg_sel;
  logic [1:0] bank_sel;
  logic [7:0] byte1, byte2, ext_wdata, ext_rdata, acc, stack_ptr, m_acc, a;
  logic [15:0] next_pc, ext_addr, ptr16, jump_target, m_pc;
  logic m_c, m_j;
  logic [15:0] m_ptr;
  logic [7:0] m_sp;
  logic [2:0] m_reg;
  int stall;
  ep::op_t op;
  ep::logic_fn_t fn;
  ep::mem_space_t ext_space;
  ep::op_t rots[4] = '{ep::op_rot_left, ep::op_rot_left_c,
                       ep::op_rot_right, ep::op_rot_right_c};
  note_t notes[$];
  int fails, compares;

  cpu_logic_move_bit_instr_exec cpu_logic_move_bit_instr_exec_i (
    .clk(clk), .rst_n(rst_n), .ce(ce), .start(start), .op(op), .fn(fn),
    .reg_sel(reg_sel), .byte1(byte1), .byte2(byte2), .next_pc(next_pc),
    .bank_sel(bank_sel), .ready(ready), .done(done), .illegal(illegal),
    .ext_rd(ext_rd), .ext_wr(ext_wr), .ext_space(ext_space),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
    .acc(acc), .carry(carry), .ptr16(ptr16), .stack_ptr(stack_ptr),
    .jump_taken(jump_taken), .jump_target(jump_target));
  ext_mem_model ext_mem_model_i (
    .clk(clk), .ext_rd(ext_rd), .ext_wr(ext_wr), .ext_space(ext_space),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // one request at a time; the note carries the expected cycle count
  task run(ep::op_t o, logic [7:0] b1, logic [7:0] b2, int f, int n);
    note_t nt;
    @(posedge clk);
    op <= o;
    fn <= ep::logic_fn_t'(f);
    byte1 <= b1;
    byte2 <= b2;
    next_pc <= m_pc;
    reg_sel <= m_reg;
    start <= 1'b1;
    nt.t0 = $time;
    nt.n = n + stall;
    nt.a = m_acc;
    nt.c = m_c;
    nt.j = m_j;
    nt.p = m_ptr;
    nt.s = m_sp;
    notes.push_back(nt);
    m_j = 1'b0;
    @(posedge clk);
    start <= 1'b0;
    // ce low must freeze the count, so done slips by the stall
    if (stall > 0) begin
      ce <= 1'b0;
      repeat (stall) @(posedge clk);
      ce <= 1'b1;
    end
    #1;
    for (int i = 0; i < 8 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check("done", 16'(done), 16'h0001);
  endtask

  always @(posedge clk) if (rst_n && done === 1'b1) begin
    note_t nt;
    nt = notes.pop_front();
    check("cycles", 16'(($time - nt.t0) / 10 - 1), 16'(nt.n));
    check("ready", 16'(ready), 16'h0001);
    check("illegal", 16'(illegal), 16'h0000);
    #1;
    check("acc", 16'(acc), 16'(nt.a));
    check("carry", 16'(carry), 16'(nt.c));
    check("jump_taken", 16'(jump_taken), 16'(nt.j));
    check("ptr16", ptr16, nt.p);
    check("stack_ptr", 16'(stack_ptr), 16'(nt.s));
  end

  initial begin
    #100000;
    fails++;
    tally_and_finish;
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    start = 1'b0;
    op = ep::op_nop;
    fn = ep::and_op;
    {reg_sel, bank_sel, byte1, byte2, next_pc} = '0;
    {m_acc, m_c, m_pc, fails, compares} = '0;
    {m_j, m_ptr, m_reg, stall} = '0;
    m_sp = ep::SP_RESET;
    void'($urandom(7));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      m_reg = 3'($urandom);
      a = 8'($urandom);
      m_acc = 8'($urandom);
      run(ep::op_cp_a_imm, m_acc, 8'h00, 0, 2);
      m_acc = i == 0 ? m_acc & a : i == 1 ? m_acc | a : m_acc ^ a;
      run(ep::op_la_imm, a, 8'h00, i, 2);
    end
    $display("test logic done");
    for (int i = 0; i < 4; i++) begin
      m_c = i[0];
      run(i[0] ? ep::op_set_c : ep::op_clr_c, 8'h00, 8'h00, 0, 1);
      case (i)
        0: m_acc = {m_acc[6:0], m_acc[7]};
        1: {m_c, m_acc} = {m_acc, m_c};
        2: m_acc = {m_acc[0], m_acc[7:1]};
        default: {m_acc, m_c} = {m_c, m_acc};
      endcase
      run(rots[i], 8'h00, 8'h00, 0, 1);
    end
    m_acc = {m_acc[3:0], m_acc[7:4]};
    run(ep::op_nib_swap, 8'h00, 8'h00, 0, 1);
    $display("test rotate done");
    m_acc = 8'h90 ^ 8'ha5;
    run(ep::op_cp_a_dir, 8'h90, 8'h00, 0, 2);
    m_ptr = 16'h0040;
    run(ep::op_load_ptr, 8'h00, 8'h40, 0, 3);
    run(ep::op_xram_wr_ptr, 8'h00, 8'h00, 0, 4);
    a = m_acc;
    m_acc = 8'h00;
    run(ep::op_clr_a, 8'h00, 8'h00, 0, 1);
    m_acc = a;
    run(ep::op_xram_rd_ptr, 8'h00, 8'h00, 0, 3);
    m_acc = (8'h40 + a) ^ 8'ha5 ^ 8'h02;
    run(ep::op_code_ptr, 8'h00, 8'h00, 0, 5);
    m_acc = m_acc ^ 8'ha5 ^ 8'h02;
    run(ep::op_code_prog, 8'h00, 8'h00, 0, 4);
    stall = 2;
    m_acc = m_acc ^ 8'h9c ^ 8'ha5;
    run(ep::op_la_dir, 8'h9c, 8'h00, 2, 2);
    stall = 0;
    m_sp = m_sp + 8'h01;
    run(ep::op_push, 8'h9c, 8'h00, 0, 3);
    m_sp = m_sp - 8'h01;
    run(ep::op_pop, 8'ha0, 8'h00, 0, 2);
    m_acc = 8'h9c ^ 8'ha5;
    run(ep::op_cp_a_dir, 8'ha0, 8'h00, 0, 2);
    $display("test memory done");
    run(ep::op_ld_imm, 8'h31, 8'h5a, 1, 3);
    m_acc = 8'h5a;
    run(ep::op_cp_a_dir, 8'h31, 8'h00, 0, 2);
    m_reg = 3'h1;
    a = m_acc;
    run(ep::op_cp_reg_imm, 8'h30, 8'h00, 0, 2);
    m_acc = {a[7:4], 4'h0};
    run(ep::op_trade_digit, 8'h00, 8'h00, 0, 3);
    m_acc = {4'h0, a[3:0]};
    run(ep::op_trade_ind, 8'h00, 8'h00, 0, 3);
    m_acc = a;
    run(ep::op_la_ind, 8'h00, 8'h00, 1, 2);
    run(ep::op_xram_wr_ind, 8'h00, 8'h00, 0, 5);
    m_acc = 8'h00;
    run(ep::op_clr_a, 8'h00, 8'h00, 0, 1);
    m_acc = a;
    run(ep::op_xram_rd_ind, 8'h00, 8'h00, 0, 4);
    m_reg = 3'($urandom);
    m_acc = (m_reg == 3'h1) ? 8'h30 : 8'h00;
    run(ep::op_trade_reg, 8'h00, 8'h00, 0, 2);
    m_acc = a;
    run(ep::op_cp_a_reg, 8'h00, 8'h00, 0, 1);
    m_acc = 8'h00;
    run(ep::op_la_reg, 8'h00, 8'h00, 2, 1);
    $display("test register done");
    m_c = 1'b1;
    run(ep::op_c_from_bit, 8'h9b, 8'h00, 0, 2);
    run(ep::op_set_bit, 8'h03, 8'h00, 0, 3);
    m_j = 1'b1;
    run(ep::op_jmp_test_clr, 8'h03, 8'h04, 0, 5);
    m_c = 1'b0;
    run(ep::op_c_from_bit, 8'h03, 8'h00, 0, 2);
    run(ep::op_jmp_test_clr, 8'h03, 8'h04, 0, 5);
    m_c = 1'b1;
    run(ep::op_orn_c, 8'h03, 8'h00, 0, 2);
    $display("test bit done");
    for (int i = 0; i < 2; i++) begin
      m_pc = 16'($urandom);
      m_j = m_c ^ i[0];
      run(i[0] ? ep::op_jmp_c_clr : ep::op_jmp_c_set, 8'hf0, 8'h00, 0, 3);
      @(posedge clk);
      #1;
      check("jump_taken", 16'(jump_taken), 16'(m_c ^ i[0]));
      if (m_c ^ i[0])
        check("jump_target", jump_target, m_pc - 16'h0010);
    end
    $display("test jump done");
    tally_and_finish;
  end
endmodule
